// ==== verilog/rclss_defines.vh ====
/*
  Register map, field positions, reset values and timing constants of the
  reclose shot sequencer. Assumes inclusion by bare name from the design.
*/
`ifndef RCLSS_DEFINES_VH
`define RCLSS_DEFINES_VH
// ==========================================================
// Register byte addresses
`define RCLSS_CTRL_ADDR      12'h000
`define RCLSS_RECLAIM_ADDR   12'h004
`define RCLSS_DEAD_ADDR      12'h008
`define RCLSS_START_ADDR     12'h00c
`define RCLSS_DISCR_ADDR     12'h010
`define RCLSS_STATUS_ADDR    12'h014
`define RCLSS_TOTAL_ADDR     12'h018
`define RCLSS_FAIL_ADDR      12'h01c
`define RCLSS_SHOTCNT_ADDR   12'h040
// ==========================================================
// Control fields
`define RCLSS_CTRL_EN_BIT    0
`define RCLSS_CTRL_RESET     32'h0000_0001
// ==========================================================
// Timing, in milliseconds except the clock rate in Hz; one tick per millisecond
`define RCLSS_CLK_HZ         50000000
`define RCLSS_TICK_MS        1
`define RCLSS_FINAL_HOLD_MS  500
`define RCLSS_RECLAIM_RESET  32'h0000_2710
`define RCLSS_DEAD_RESET     32'h0000_1388
`define RCLSS_START_RESET    32'h0000_0014
`define RCLSS_DISCR_RESET    32'h0000_0014
// ==========================================================
// Sequencer states
`define RCLSS_ST_INIT        4'h0
`define RCLSS_ST_RECLAIM     4'h1
`define RCLSS_ST_READY       4'h2
`define RCLSS_ST_WAIT_OPEN   4'h3
`define RCLSS_ST_WAIT_CLOSE  4'h4
`define RCLSS_ST_DISCR       4'h5
`define RCLSS_ST_LOCKED      4'h6
`define RCLSS_ST_FINAL       4'h7
`define RCLSS_ST_CB_FAIL     4'h8
`define RCLSS_ST_INHIBIT     4'h9
`define RCLSS_ST_START       4'ha
`define RCLSS_ST_DEAD        4'hb
// Active timer codes
`define RCLSS_TMR_RECLAIM    2'h0
`define RCLSS_TMR_START      2'h1
`define RCLSS_TMR_DEAD       2'h2
`define RCLSS_TMR_DISCR      2'h3
`endif

// ==== verilog/rclss_sequencer.v ====
/*
  Automatic reclose shot sequencer with an AHB-Lite register slave.
  Assumes breaker feedback, fault start, request and block inputs arrive
  asynchronously from pins; a single 50 MHz clock; single-word transfers.
*/
// Chosen here: register access over AHB-Lite and the address map.
`include "rclss_defines.vh"
module rclss_sequencer #(
  parameter SHOTS         = 5,
  parameter TICK_CYC      = `RCLSS_CLK_HZ / 1000 * `RCLSS_TICK_MS,
  parameter FINAL_HOLD_MS = `RCLSS_FINAL_HOLD_MS
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        fault_start,
  input  wire        reclose_req1,
  input  wire        reclose_req2,
  input  wire        critical_req,
  input  wire        close_block,
  input  wire        breaker_is_open,
  input  wire        breaker_is_closed,
  output reg         breaker_open_command,
  output reg         breaker_close_command,
  output reg         reclose_running,
  output reg  [2:0]  final_trip
);
  // ==========================================================
  // Input synchronisers
  reg [6:0] sync1_r;
  reg [6:0] sync2_r;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
    end
    else
    begin
      sync1_r <= {breaker_is_closed, breaker_is_open, close_block, critical_req,
                  reclose_req2, reclose_req1, fault_start};
      sync2_r <= sync1_r;
    end
  end
  wire flt   = sync2_r[0];
  wire req1  = sync2_r[1];
  wire req2  = sync2_r[2];
  wire crit  = sync2_r[3];
  wire blk   = sync2_r[4];
  wire cb_op = sync2_r[5];
  wire cb_cl = sync2_r[6];

  // ==========================================================
  // Millisecond tick divider
  reg [31:0] div_r;
  wire       tick = (div_r == TICK_CYC - 1);
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_r <= 32'h0;
    else if (tick)
      div_r <= 32'h0;
    else
      div_r <= div_r + 32'h1;
  end

  // ==========================================================
  // Registers
  reg [31:0] ctrl_r;
  reg [31:0] reclaim_r;
  reg [31:0] dead_r;
  reg [31:0] start_r;
  reg [31:0] discr_r;
  reg [31:0] total_start_counter;
  reg [31:0] fail_cnt_r;
  reg [31:0] shot_cnt_r [0:2*SHOTS-1];
  reg [3:0]  state_r;
  reg [2:0]  shot_r;
  reg        line_r;
  reg [1:0]  active_timer_indicator;
  reg [31:0] tmr_r;
  wire       enable = ctrl_r[`RCLSS_CTRL_EN_BIT];

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  reg        wr_pend_r;
  reg [11:0] wr_addr_r;
  wire       acc = hsel & htrans[1] & hready;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend_r <= acc & hwrite;
      wr_addr_r <= haddr[11:0];
    end
  end
  integer k;
  reg [31:0] rd_nxt;
  always @*
  begin
    rd_nxt = 32'h0;
    if (haddr[11:0] == `RCLSS_CTRL_ADDR)
      rd_nxt = ctrl_r;
    else if (haddr[11:0] == `RCLSS_RECLAIM_ADDR)
      rd_nxt = reclaim_r;
    else if (haddr[11:0] == `RCLSS_DEAD_ADDR)
      rd_nxt = dead_r;
    else if (haddr[11:0] == `RCLSS_START_ADDR)
      rd_nxt = start_r;
    else if (haddr[11:0] == `RCLSS_DISCR_ADDR)
      rd_nxt = discr_r;
    else if (haddr[11:0] == `RCLSS_STATUS_ADDR)
      rd_nxt = {22'h0, active_timer_indicator, 1'b0, shot_r, state_r};
    else if (haddr[11:0] == `RCLSS_TOTAL_ADDR)
      rd_nxt = total_start_counter;
    else if (haddr[11:0] == `RCLSS_FAIL_ADDR)
      rd_nxt = fail_cnt_r;
    else
      for (k = 0; k < 2*SHOTS; k = k + 1)
        if (haddr[11:0] == `RCLSS_SHOTCNT_ADDR + 4*k)
          rd_nxt = shot_cnt_r[k];
  end
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0;
    else if (acc & ~hwrite)
      hrdata <= rd_nxt;
  end
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r    <= `RCLSS_CTRL_RESET;
      reclaim_r <= `RCLSS_RECLAIM_RESET;
      dead_r    <= `RCLSS_DEAD_RESET;
      start_r   <= `RCLSS_START_RESET;
      discr_r   <= `RCLSS_DISCR_RESET;
    end
    else if (wr_pend_r)
    begin
      if (wr_addr_r == `RCLSS_CTRL_ADDR)
        ctrl_r <= {31'h0, hwdata[0]};
      else if (wr_addr_r == `RCLSS_RECLAIM_ADDR)
        reclaim_r <= hwdata;
      else if (wr_addr_r == `RCLSS_DEAD_ADDR)
        dead_r <= hwdata;
      else if (wr_addr_r == `RCLSS_START_ADDR)
        start_r <= hwdata;
      else if (wr_addr_r == `RCLSS_DISCR_ADDR)
        discr_r <= hwdata;
    end
  end

  // ==========================================================
  // Shot sequencer; timers count milliseconds
  wire       tmr_done = (tmr_r == 32'h0);
  wire       req_any  = req1 | req2;
  wire       running  = (state_r == `RCLSS_ST_DEAD) || (state_r == `RCLSS_ST_DISCR) ||
                        (state_r == `RCLSS_ST_WAIT_CLOSE);
  reg        shot_start;
  reg        shot_fail;
  reg [2:0]  final_set;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r                <= `RCLSS_ST_INIT;
      shot_r                 <= 3'h0;
      line_r                 <= 1'b0;
      tmr_r                  <= 32'h0;
      active_timer_indicator <= `RCLSS_TMR_RECLAIM;
      breaker_open_command   <= 1'b0;
      breaker_close_command  <= 1'b0;
      reclose_running        <= 1'b0;
      shot_start             <= 1'b0;
      shot_fail              <= 1'b0;
      final_set              <= 3'h0;
    end
    else
    begin
      shot_start <= 1'b0;
      shot_fail  <= 1'b0;
      final_set  <= 3'h0;
      if (tick && !tmr_done)
        tmr_r <= tmr_r - 32'h1;
      if (!enable)
      begin
        state_r               <= `RCLSS_ST_INHIBIT;
        breaker_open_command  <= 1'b0;
        breaker_close_command <= 1'b0;
        reclose_running       <= 1'b0;
      end
      else if (crit && running)
      begin
        // Abort leaves the breaker tripped and locked out
        state_r               <= `RCLSS_ST_FINAL;
        breaker_open_command  <= 1'b1;
        breaker_close_command <= 1'b0;
        reclose_running       <= 1'b0;
        final_set             <= 3'h4;
        shot_fail             <= 1'b1;
      end
      else
        case (state_r)
          `RCLSS_ST_INIT, `RCLSS_ST_INHIBIT:
            state_r <= `RCLSS_ST_READY;
          `RCLSS_ST_READY:
            if (flt && req_any)
            begin
              state_r                <= `RCLSS_ST_START;
              shot_r                 <= 3'h0;
              line_r                 <= ~req1;
              tmr_r                  <= start_r;
              active_timer_indicator <= `RCLSS_TMR_START;
              shot_start             <= 1'b1;
            end
          `RCLSS_ST_START:
            if (!flt)
              state_r <= `RCLSS_ST_READY;
            else if (tmr_done)
            begin
              state_r              <= `RCLSS_ST_WAIT_OPEN;
              breaker_open_command <= 1'b1;
            end
          `RCLSS_ST_WAIT_OPEN:
            if (cb_op)
            begin
              breaker_open_command   <= 1'b0;
              state_r                <= `RCLSS_ST_DEAD;
              tmr_r                  <= dead_r;
              active_timer_indicator <= `RCLSS_TMR_DEAD;
              reclose_running        <= 1'b1;
            end
          `RCLSS_ST_DEAD:
            if (tmr_done && !blk)
            begin
              state_r               <= `RCLSS_ST_WAIT_CLOSE;
              breaker_close_command <= 1'b1;
              reclose_running       <= 1'b0;
            end
          `RCLSS_ST_WAIT_CLOSE:
            if (cb_cl)
            begin
              breaker_close_command  <= 1'b0;
              state_r                <= `RCLSS_ST_DISCR;
              tmr_r                  <= discr_r;
              active_timer_indicator <= `RCLSS_TMR_DISCR;
            end
          `RCLSS_ST_DISCR:
            if (tmr_done && flt)
            begin
              breaker_open_command <= 1'b1;
              shot_fail            <= 1'b1;
              if (shot_r == SHOTS - 1)
              begin
                state_r   <= `RCLSS_ST_FINAL;
                final_set <= line_r ? 3'h2 : 3'h1;
              end
              else
              begin
                shot_r     <= shot_r + 3'h1;
                shot_start <= 1'b1;
                state_r    <= `RCLSS_ST_WAIT_OPEN;
              end
            end
            else if (tmr_done)
            begin
              state_r                <= `RCLSS_ST_RECLAIM;
              tmr_r                  <= reclaim_r;
              active_timer_indicator <= `RCLSS_TMR_RECLAIM;
            end
          `RCLSS_ST_RECLAIM:
            if (tmr_done)
            begin
              state_r <= `RCLSS_ST_READY;
              shot_r  <= 3'h0;
            end
          `RCLSS_ST_FINAL:
            if (cb_op)
            begin
              breaker_open_command <= 1'b0;
              state_r              <= `RCLSS_ST_LOCKED;
            end
          `RCLSS_ST_LOCKED:
            if (!flt && !req_any)
            begin
              state_r <= `RCLSS_ST_READY;
              shot_r  <= 3'h0;
            end
          default:
            state_r <= `RCLSS_ST_CB_FAIL;
        endcase
    end
  end

  // ==========================================================
  // Counters and final trip hold timers
  integer j;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      total_start_counter <= 32'h0;
      fail_cnt_r          <= 32'h0;
      for (j = 0; j < 2*SHOTS; j = j + 1)
        shot_cnt_r[j] <= 32'h0;
    end
    else
    begin
      if (shot_start)
      begin
        total_start_counter <= total_start_counter + 32'h1;
        shot_cnt_r[line_r*SHOTS + shot_r] <= shot_cnt_r[line_r*SHOTS + shot_r] + 32'h1;
      end
      if (shot_fail)
        fail_cnt_r <= fail_cnt_r + 32'h1;
    end
  end
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_hold
      // Each hold counter is local to its slice so only one process drives it
      reg [31:0] hold_r;
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          hold_r        <= 32'h0;
          final_trip[g] <= 1'b0;
        end
        else if (final_set[g])
        begin
          hold_r        <= FINAL_HOLD_MS;
          final_trip[g] <= 1'b1;
        end
        else if (tick && hold_r != 32'h0)
        begin
          hold_r        <= hold_r - 32'h1;
          final_trip[g] <= (hold_r != 32'h1);
        end
      end
    end
  endgenerate
endmodule // rclss_sequencer

// ==== tb/rclss_properties.sv ====
/*
  Concurrent checks on the reclose shot sequencer top-level ports.
  Assumes one hclk domain, hresetn async active low, bound by name below.
*/
// ==========================================================
// Checker
module rclss_properties #(
  parameter TICK_CYC      = 10,
  parameter FINAL_HOLD_MS = 5
) (
  input wire       hclk,
  input wire       hresetn,
  input wire       hreadyout,
  input wire       hresp,
  input wire       fault_start,
  input wire       critical_req,
  input wire       close_block,
  input wire       breaker_is_open,
  input wire       breaker_is_closed,
  input wire       breaker_open_command,
  input wire       breaker_close_command,
  input wire       reclose_running,
  input wire [2:0] final_trip
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned ft_cnt;
  // Length of the current final trip pulse
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ft_cnt <= 0;
    else if (final_trip != 3'h0)
      ft_cnt <= ft_cnt + 1;
    else
      ft_cnt <= 0;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  property p_open_cause;
    $rose(breaker_open_command) |-> $past(fault_start, 3) || $past(critical_req, 3);
  endproperty
  property p_open_release;
    breaker_is_open && breaker_open_command |-> ##[1:6] !breaker_open_command;
  endproperty
  property p_close_open;
    $rose(breaker_close_command) |-> breaker_is_open;
  endproperty
  property p_close_release;
    breaker_is_closed && breaker_close_command |-> ##[1:6] !breaker_close_command;
  endproperty
  property p_block;
    close_block && $past(close_block) && $past(close_block, 3) |-> !$rose(breaker_close_command);
  endproperty
  property p_run_noclose;
    reclose_running |-> !breaker_close_command;
  endproperty
  property p_ft_max;
    final_trip != 3'h0 |-> ft_cnt < (FINAL_HOLD_MS + 1) * TICK_CYC + 4;
  endproperty
  property p_ft_min;
    ft_cnt != 0 && final_trip == 3'h0 |-> ft_cnt >= (FINAL_HOLD_MS - 1) * TICK_CYC;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus response not okay");
  a_open_cause: assert property (p_open_cause) else $error("open without cause");
  a_open_release: assert property (p_open_release) else $error("open held");
  a_close_open: assert property (p_close_open) else $error("close while closed");
  a_close_release: assert property (p_close_release) else $error("close held");
  a_block: assert property (p_block) else $error("close while blocked");
  a_run_noclose: assert property (p_run_noclose) else $error("running with close");
  a_ft_max: assert property (p_ft_max) else $error("final trip too long");
  a_ft_min: assert property (p_ft_min) else $error("final trip too short");
  c_close: cover property ($rose(breaker_close_command));
  c_run: cover property ($rose(reclose_running));
  c_crit: cover property ($rose(final_trip[2]));
endmodule // rclss_properties
bind rclss_sequencer rclss_properties #(
  .TICK_CYC      (TICK_CYC),
  .FINAL_HOLD_MS (FINAL_HOLD_MS)
) rclss_properties_i (
  .hclk                  (hclk),
  .hresetn               (hresetn),
  .hreadyout             (hreadyout),
  .hresp                 (hresp),
  .fault_start           (fault_start),
  .critical_req          (critical_req),
  .close_block           (close_block),
  .breaker_is_open       (breaker_is_open),
  .breaker_is_closed     (breaker_is_closed),
  .breaker_open_command  (breaker_open_command),
  .breaker_close_command (breaker_close_command),
  .reclose_running       (reclose_running),
  .final_trip            (final_trip)
);

// ==== tb/rclss_breaker.sv ====
/*
  Behavioural circuit breaker with position feedback.
  Assumes level commands from the sequencer; starts closed.
*/
// ==========================================================
// Breaker model
module rclss_breaker #(
  parameter TRAVEL = 5
) (
  input  wire  hclk,
  input  wire  open_cmd,
  input  wire  close_cmd,
  output logic is_open,
  output logic is_closed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic open_r = 1'b0;
  int   cnt    = 0;
  // Contacts move only after a travel time, so a short command is not enough
  always @(posedge hclk)
    if ((open_cmd && !open_r) || (close_cmd && open_r))
    begin
      cnt <= cnt + 1;
      if (cnt == TRAVEL)
        open_r <= !open_r;
    end
    else
      cnt <= 0;
  assign is_open   = open_r;
  assign is_closed = !open_r;
endmodule // rclss_breaker

// ==== tb/tb.sv ====
/*
  Self-checking bench: AHB-Lite master tasks, breaker model, shot scenarios.
  Assumes timings are shortened through TICK_CYC and the timing registers.
*/
`include "rclss_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam TK = 10;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2, final_trip;
  logic        hreadyout, hresp, fault_start = 0, reclose_req1 = 0, reclose_req2 = 0;
  logic        critical_req = 0, close_block = 0, b_open, b_closed, open_c, close_c, running;
  int          err_total = 0, samples_checked = 0, cyc = 0, n;
  always #10 hclk = !hclk;
  rclss_sequencer #(.TICK_CYC(TK), .FINAL_HOLD_MS(5)) rclss_sequencer_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fault_start(fault_start),
    .reclose_req1(reclose_req1), .reclose_req2(reclose_req2), .critical_req(critical_req),
    .close_block(close_block), .breaker_is_open(b_open), .breaker_is_closed(b_closed),
    .breaker_open_command(open_c), .breaker_close_command(close_c),
    .reclose_running(running), .final_trip(final_trip));
  rclss_breaker rclss_breaker_i (.hclk(hclk), .open_cmd(open_c), .close_cmd(close_c),
    .is_open(b_open), .is_closed(b_closed));
  // ==========================================================
  // Shared tasks
  task final_report;
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task step(input int c);
    repeat (c) @(posedge hclk);
  endtask
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task do_reset;
    hresetn <= 0;
    step(6);
    hresetn <= 1;
    step(4);
  endtask
  task wait_cmd(input logic cls);
    while ((cls ? close_c : open_c) !== 1'b1) @(posedge hclk);
    while ((cls ? b_closed : b_open) !== 1'b1) @(posedge hclk);
  endtask
  // ==========================================================
  // Scenarios
  task t_regs;
    static logic [11:0] a[6] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h100};
    static logic [31:0] e[6] = '{32'h1, 32'h2710, 32'h1388, 32'h14, 32'h14, 32'h0};
    static logic [31:0] s[5] = '{32'h1, 32'h5, 32'h4, 32'h2, 32'h3};
    for (int i = 0; i < 6; i++)
    begin
      ahb(0, a[i], 0);
      check(rd, e[i]);
    end
    for (int i = 1; i < 5; i++)
    begin
      ahb(1, a[i], s[i]);
      ahb(0, a[i], 0);
      check(rd, s[i]);
    end
    ahb(1, 12'h018, 32'h55);
    ahb(0, 12'h018, 0);
    check(rd, 32'h0);
    ahb(0, 12'h014, 0);
    check(rd[6:0], 7'h02);
  endtask
  task t_shots;
    fault_start <= 1;
    reclose_req1 <= 1;
    n = 0;
    while (open_c !== 1'b1)
    begin
      @(posedge hclk);
      n++;
    end
    // Timers run on the free millisecond tick, so a delay of N lasts N-1 to N ticks
    check(n >= TK + 6 && n <= 2 * TK + 5, 1);
    while (b_open !== 1'b1) @(posedge hclk);
    for (n = 0; close_c !== 1'b1; n++)
    begin
      @(posedge hclk);
      if (n == 2 * TK)
        check(running, 1);
      if (n == 2 * TK)
        check(open_c, 0);
    end
    check(n >= 3 * TK + 5 && n <= 4 * TK + 4, 1);
    check(running, 0);
    wait_cmd(1);
    wait_cmd(0);
    ahb(0, 12'h014, 0);
    check(rd[6:4], 3'h1);
    fault_start <= 0;
    wait_cmd(1);
    step(4 * TK + 10);
    ahb(0, 12'h014, 0);
    check(rd[3:0], 4'h1);
    step(6 * TK + 10);
    ahb(0, 12'h014, 0);
    check(rd[6:0], 7'h02);
    ahb(0, 12'h018, 0);
    check(rd, 32'h2);
    ahb(0, 12'h01c, 0);
    check(rd, 32'h1);
    ahb(0, 12'h040, 0);
    check(rd, 32'h1);
    ahb(0, 12'h044, 0);
    check(rd, 32'h1);
    reclose_req1 <= 0;
  endtask
  task t_block;
    reclose_req2 <= 1;
    fault_start <= 1;
    while (b_open !== 1'b1) @(posedge hclk);
    close_block <= 1;
    step(7 * TK);
    check(close_c, 0);
    close_block <= 0;
    step(5);
    check(close_c, 1);
    fault_start <= 0;
    while (b_closed !== 1'b1) @(posedge hclk);
    step(4 * TK + 10);
    critical_req <= 1;
    step(8);
    check(final_trip, 3'h0);
    critical_req <= 0;
    step(6 * TK);
    ahb(0, 12'h054, 0);
    check(rd, 32'h1);
    reclose_req2 <= 0;
  endtask
  task t_critical;
    fault_start <= 1;
    reclose_req1 <= 1;
    while (b_open !== 1'b1) @(posedge hclk);
    step(TK);
    critical_req <= 1;
    step(8);
    check(final_trip, 3'h4);
    ahb(0, 12'h014, 0);
    // Breaker is already open here, so final trip has moved on to locked
    check(rd[3:0], 4'h6);
    for (n = 0; final_trip !== 3'h0 && n < 100; n++) @(posedge hclk);
    check(n >= 3 * TK && n <= 5 * TK, 1);
    critical_req <= 0;
    fault_start <= 0;
    reclose_req1 <= 0;
  endtask
  task t_inhibit;
    do_reset;
    ahb(1, 12'h000, 32'h0);
    step(5);
    ahb(0, 12'h014, 0);
    check(rd[3:0], 4'h9);
    ahb(1, 12'h100, 32'h7);
    ahb(0, 12'h100, 0);
    check(rd, 32'h0);
  endtask
  // ==========================================================
  // Watchdog and main sequence
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      final_report;
    end
  end
  initial
  begin
    do_reset;
    t_regs;
    t_shots;
    t_block;
    t_critical;
    t_inhibit;
    final_report;
  end
endmodule // tb
